// file: common/ppc_pkg.sv
// Constants shared by the processor-port configuration control block.
// Assumes a 100 MHz system clock feeding every module of the block.
package ppc_pkg;
  // Register select values: command register and data/status register.
  localparam logic REG_SEL_CMD = 1'b0;
  localparam logic REG_SEL_STATUS = 1'b1;
  // Command byte layout.
  localparam int CMD_FUNC_LSB = 0;
  localparam int CMD_OUT_EN_BIT = 4;
  localparam int CMD_IN_EN_BIT = 5;
  localparam int CMD_OSC_DIS_BIT = 6;
  localparam int CMD_BOOST_BIT = 7;
  // Status byte layout.
  localparam int STAT_ID_ERR_BIT = 0;
  localparam int STAT_ROW_ERR_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam logic [4:0] STAT_RSVD_VALUE = 5'h00;
  // Function codes.
  localparam logic [3:0] FN_NOP = 4'h0;
  localparam logic [3:0] FN_RESET_DEVICE = 4'h1;
  localparam logic [3:0] FN_LOAD_CONFIG = 4'h2;
  localparam logic [3:0] FN_RESERVED_LOW = 4'h7;
  // Reset values of the command enables.
  localparam logic CMD_ENABLE_RESET = 1'b0;
  // Timing: configuration clock derived from the system clock.
  localparam int SYS_CLK_NS = 10;
  localparam int CFG_CLK_NS = 400;
  localparam int CFG_DIV = (CFG_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [7:0] ROW_XFER_TICKS = 8'h08;
  localparam logic [7:0] RESET_TICKS = 8'h10;
endpackage

// file: common/ppc_tmr_if.sv
// Link between the port controller and its configuration-clock busy timer.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
`default_nettype none
interface ppc_tmr_if;
  logic start;
  logic [7:0] ticks;
  logic ext_sel;
  logic ext_clk;
  logic tick;
  logic busy;
  modport ctrl (output start, output ticks, output ext_sel, output ext_clk,
    input tick, input busy);
  modport tmr (input start, input ticks, input ext_sel, input ext_clk,
    output tick, output busy);
endinterface
`default_nettype wire

// file: design/ppc_busy_timer.sv
// Configuration clock enable and busy interval counter.
// Assumes the external clock level is already synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module ppc_busy_timer
  import ppc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Controller side.
  ppc_tmr_if.tmr tif
);
  logic [6:0] div_reg;
  logic ext_prev_reg;
  logic [7:0] cnt_reg;
  logic int_tick;
  logic ext_tick;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      div_reg <= 7'h00;
    else if (div_reg == 7'(CFG_DIV - 1))
      div_reg <= 7'h00;
    else
      div_reg <= div_reg + 7'h01;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ext_prev_reg <= 1'b0;
    else
      ext_prev_reg <= tif.ext_clk;
  end

  assign int_tick = (div_reg == 7'(CFG_DIV - 1));
  assign ext_tick = tif.ext_clk & ~ext_prev_reg;
  assign tif.tick = tif.ext_sel ? ext_tick : int_tick;

  // The interval is counted only in configuration clock ticks.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cnt_reg <= 8'h00;
    else if (tif.start)
      cnt_reg <= tif.ticks;
    else if (tif.tick && cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
  end

  assign tif.busy = (cnt_reg != 8'h00);
endmodule
`default_nettype wire

// file: design/ppc_port_ctrl.sv
// Processor-port command and status control of the configuration interface.
// Assumes a synchronous byte-wide processor port and a configuration engine
// that reports row ends and check errors as one-cycle pulses.
//
// What this block does
// - Command bit 4 enables outputs, after inputs.
// - Command bit 5 enables inputs, if no error flagged.
// - Bit 6 stops oscillator only with external clock.
// - Status bit 0 wrong ID, bit 1 row check.
// - Status bit 2 mirrors the busy output.
// - Status bits 7 to 3 reserved, ignored.
// - Busy intervals counted in configuration clock cycles.
// - After an error, data writes are rejected.
`timescale 1ns/1ns
`default_nettype none
module ppc_port_ctrl
  import ppc_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  // Processor port.
  input wire logic CHIP_SEL_IN,
  input wire logic WRITE_IN,
  input wire logic READ_IN,
  input wire logic REGISTER_SELECT_IN,
  input wire logic [7:0] PROC_DATA_IN,
  output logic [7:0] PROC_DATA_OUT,
  output logic PROC_DATA_OE_N_OUT,
  output logic BUSY_OUT,
  // Clock selection.
  input wire logic EXT_CLK_SEL_IN,
  input wire logic EXT_CFG_CLK_IN,
  // Configuration engine.
  input wire logic ROW_END_IN,
  input wire logic ID_ERR_IN,
  input wire logic ROW_CHECK_ERR_IN,
  output logic [3:0] FUNC_CODE_OUT,
  output logic FUNC_STROBE_OUT,
  output logic [7:0] CFG_DATA_OUT,
  output logic CFG_DATA_STROBE_OUT,
  // Array controls.
  output logic USER_IN_EN_OUT,
  output logic USER_OUT_EN_OUT,
  output logic OSC_RUN_OUT,
  output logic BOOST_EN_OUT
);
  ppc_tmr_if tif ();

  logic cmd_wr;
  logic data_wr;
  logic stat_rd;
  logic err_any;
  logic fn_valid;
  logic data_ok;
  logic clear_err;
  logic in_en_reg;
  logic out_en_reg;
  logic osc_dis_reg;
  logic boost_reg;
  logic id_err_reg;
  logic row_err_reg;
  logic [3:0] func_reg;
  logic func_stb_reg;
  logic [7:0] cfg_data_reg;
  logic cfg_stb_reg;
  logic [7:0] rdata_reg;
  logic oe_n_reg;

  // Reserved function codes decode, used for the strobe and the checks.
  function automatic logic fn_reserved(input logic [3:0] code);
    fn_reserved = code[3] || (code == FN_RESERVED_LOW);
  endfunction

  assign cmd_wr = CHIP_SEL_IN && WRITE_IN && (REGISTER_SELECT_IN == REG_SEL_CMD);
  assign data_wr = CHIP_SEL_IN && WRITE_IN && (REGISTER_SELECT_IN == REG_SEL_STATUS);
  assign stat_rd = CHIP_SEL_IN && READ_IN && (REGISTER_SELECT_IN == REG_SEL_STATUS);
  assign err_any = id_err_reg || row_err_reg;
  assign fn_valid = !fn_reserved(PROC_DATA_IN[CMD_FUNC_LSB +: 4]);
  assign data_ok = data_wr && !err_any && !tif.busy;
  assign clear_err = cmd_wr && fn_valid &&
    (PROC_DATA_IN[CMD_FUNC_LSB +: 4] == FN_RESET_DEVICE ||
     PROC_DATA_IN[CMD_FUNC_LSB +: 4] == FN_LOAD_CONFIG);

  // Command enables decode from the upper nibble on every command write.
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      out_en_reg <= CMD_ENABLE_RESET;
      osc_dis_reg <= CMD_ENABLE_RESET;
      boost_reg <= CMD_ENABLE_RESET;
    end
    else if (cmd_wr)
    begin
      out_en_reg <= PROC_DATA_IN[CMD_OUT_EN_BIT];
      osc_dis_reg <= PROC_DATA_IN[CMD_OSC_DIS_BIT];
      boost_reg <= PROC_DATA_IN[CMD_BOOST_BIT];
    end
  end

  // Inputs are enabled only by a command write made while no load error is flagged.
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      in_en_reg <= CMD_ENABLE_RESET;
    else if (cmd_wr)
      in_en_reg <= PROC_DATA_IN[CMD_IN_EN_BIT] && !err_any;
  end

  // Outputs follow only once inputs have been enabled for a clock.
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      USER_OUT_EN_OUT <= 1'b0;
    else
      USER_OUT_EN_OUT <= out_en_reg && in_en_reg;
  end

  assign USER_IN_EN_OUT = in_en_reg;
  assign OSC_RUN_OUT = !(osc_dis_reg && EXT_CLK_SEL_IN);
  assign BOOST_EN_OUT = boost_reg;

  // Function strobe is suppressed for reserved codes.
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      func_reg <= FN_NOP;
      func_stb_reg <= 1'b0;
    end
    else
    begin
      func_stb_reg <= cmd_wr && fn_valid;
      if (cmd_wr && fn_valid)
        func_reg <= PROC_DATA_IN[CMD_FUNC_LSB +: 4];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      cfg_data_reg <= 8'h00;
      cfg_stb_reg <= 1'b0;
    end
    else
    begin
      cfg_stb_reg <= data_ok;
      if (data_ok)
        cfg_data_reg <= PROC_DATA_IN;
    end
  end

  // Sticky error flags; a new error wins over a clearing command.
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      id_err_reg <= 1'b0;
      row_err_reg <= 1'b0;
    end
    else
    begin
      id_err_reg <= ID_ERR_IN || (id_err_reg && !clear_err);
      row_err_reg <= ROW_CHECK_ERR_IN || (row_err_reg && !clear_err);
    end
  end

  // Busy timing runs on the configuration clock.
  assign tif.start = (cmd_wr && fn_valid &&
    PROC_DATA_IN[CMD_FUNC_LSB +: 4] == FN_RESET_DEVICE) ||
    (data_ok && ROW_END_IN);
  assign tif.ticks = (cmd_wr && PROC_DATA_IN[CMD_FUNC_LSB +: 4] == FN_RESET_DEVICE) ?
    RESET_TICKS : ROW_XFER_TICKS;
  assign tif.ext_sel = EXT_CLK_SEL_IN;
  assign tif.ext_clk = EXT_CFG_CLK_IN;
  assign BUSY_OUT = tif.busy;

  ppc_busy_timer u_timer (
    .clk_in(SYS_CLK_IN),
    .nrst_in(NRST_IN),
    .tif(tif)
  );

  // Status read path.
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      rdata_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end
    else
    begin
      oe_n_reg <= !stat_rd;
      if (stat_rd)
        rdata_reg <= {STAT_RSVD_VALUE, tif.busy, row_err_reg, id_err_reg};
    end
  end

  assign PROC_DATA_OUT = rdata_reg;
  assign PROC_DATA_OE_N_OUT = oe_n_reg;
  assign FUNC_CODE_OUT = func_reg;
  assign FUNC_STROBE_OUT = func_stb_reg;
  assign CFG_DATA_OUT = cfg_data_reg;
  assign CFG_DATA_STROBE_OUT = cfg_stb_reg;

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  sequence s_read;
    stat_rd;
  endsequence
  sequence s_err_write;
    data_wr && err_any;
  endsequence

  property p_status_id;
    s_read |=> PROC_DATA_OUT[STAT_ID_ERR_BIT] == $past(id_err_reg);
  endproperty
  a_status_id: assert property (p_status_id) else $error("ID flag wrong");

  property p_status_row;
    s_read |=> PROC_DATA_OUT[STAT_ROW_ERR_BIT] == $past(row_err_reg);
  endproperty
  a_status_row: assert property (p_status_row) else $error("Row flag wrong");

  property p_status_busy;
    s_read |=> PROC_DATA_OUT[STAT_BUSY_BIT] == $past(BUSY_OUT);
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("Busy bit wrong");

  property p_status_rsvd;
    s_read |=> PROC_DATA_OUT[7:3] == STAT_RSVD_VALUE && !PROC_DATA_OE_N_OUT;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("Reserved bits");

  property p_reject;
    s_err_write |=> !CFG_DATA_STROBE_OUT;
  endproperty
  a_reject: assert property (p_reject) else $error("Data write taken after error");

  property p_osc_keep;
    !EXT_CLK_SEL_IN |-> OSC_RUN_OUT;
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("Oscillator stopped");

  property p_out_after_in;
    $rose(USER_OUT_EN_OUT) |-> $past(USER_IN_EN_OUT, 1) && USER_IN_EN_OUT;
  endproperty
  a_out_after_in: assert property (p_out_after_in) else $error("Outputs before inputs");

  property p_busy_tick;
    $fell(BUSY_OUT) |-> $past(tif.tick);
  endproperty
  a_busy_tick: assert property (p_busy_tick) else $error("Busy ended off tick");

  property p_reserved_fn;
    cmd_wr && fn_reserved(PROC_DATA_IN[3:0]) |=> !FUNC_STROBE_OUT;
  endproperty
  a_reserved_fn: assert property (p_reserved_fn) else $error("Reserved code issued");

  property p_cmd_decode;
    cmd_wr |=> BOOST_EN_OUT == $past(PROC_DATA_IN[CMD_BOOST_BIT]) ##1
      USER_OUT_EN_OUT == ($past(PROC_DATA_IN[CMD_OUT_EN_BIT], 2) && $past(USER_IN_EN_OUT));
  endproperty
  a_cmd_decode: assert property (p_cmd_decode) else $error("Command decode");

  property p_in_en_clean;
    $rose(USER_IN_EN_OUT) |-> !$past(err_any);
  endproperty
  a_in_en_clean: assert property (p_in_en_clean) else $error("Inputs enabled on error");
endmodule
`default_nettype wire

// file: tb/ppc_proc_model.sv
// Processor model that drives the byte-wide port of the control block.
// Assumes the bench calls its tasks and drives the engine inputs itself.
`timescale 1ns/1ns
`default_nettype none
module ppc_proc_model
  import ppc_pkg::*;
#(
  // Oscillator restart time of 100 us at the 10 ns bench clock.
  parameter int RESTART_CYC = 10000
)
(
  // Clock and answers.
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic [7:0] stat_in,
  input wire logic oe_n_in,
  // Port drive.
  output logic cs_out,
  output logic wr_out,
  output logic rd_out,
  output logic sel_out,
  output logic [7:0] d_out
);
  logic osc_off = 1'b0;
  // Set when a guarded data write gave up waiting for busy to drop.
  logic hung = 1'b0;
  initial {cs_out, wr_out, rd_out, sel_out, d_out} = 12'h000;
  // A rude write skips the guards so the bench can provoke refusals.
  task automatic wr(input logic sel, input logic [7:0] d, input bit rude);
    int n;
    logic [7:0] v;
    n = 0;
    v = d;
    if (!rude && sel == REG_SEL_CMD && (v[3:0] == FN_RESERVED_LOW || v[3]))
      v[3:0] = FN_NOP;
    while (!rude && sel == REG_SEL_STATUS && busy_in && n < 2000)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 2000)
      hung = 1'b1;
    @(posedge clk_in);
    #1;
    {cs_out, wr_out, sel_out, d_out} = {2'b11, sel, v};
    @(posedge clk_in);
    #1;
    {cs_out, wr_out} = 2'b00;
    d_out = ~v;
    if (sel == REG_SEL_CMD && osc_off && !v[CMD_OSC_DIS_BIT])
    begin
      repeat (RESTART_CYC) @(posedge clk_in);
      #1;
    end
    if (sel == REG_SEL_CMD)
      osc_off = v[CMD_OSC_DIS_BIT];
  endtask
  task automatic rd(output logic [7:0] s, output logic oe_n);
    @(posedge clk_in);
    #1;
    {cs_out, rd_out, sel_out} = {2'b11, REG_SEL_STATUS};
    @(posedge clk_in);
    #1;
    {cs_out, rd_out} = 2'b00;
    s = stat_in;
    oe_n = oe_n_in;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the processor-port control block.
// Assumes the processor model in this folder and a 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ppc_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, ext_sel = 1'b0, ext_clk = 1'b0;
  logic row_end = 1'b0, id_err = 1'b0, row_err = 1'b0;
  logic cs, wr, rd, sel, oe_n, busy, fstb, dstb, in_en, out_en, osc, boost;
  logic [7:0] pd, sd, cd;
  logic [3:0] fc;
  int num_errors = 0;
  int checks_done = 0;
  ppc_port_ctrl DUT (.SYS_CLK_IN(clk), .NRST_IN(nrst), .CHIP_SEL_IN(cs),
    .WRITE_IN(wr), .READ_IN(rd), .REGISTER_SELECT_IN(sel), .PROC_DATA_IN(pd),
    .PROC_DATA_OUT(sd), .PROC_DATA_OE_N_OUT(oe_n), .BUSY_OUT(busy),
    .EXT_CLK_SEL_IN(ext_sel), .EXT_CFG_CLK_IN(ext_clk), .ROW_END_IN(row_end),
    .ID_ERR_IN(id_err), .ROW_CHECK_ERR_IN(row_err), .FUNC_CODE_OUT(fc),
    .FUNC_STROBE_OUT(fstb), .CFG_DATA_OUT(cd), .CFG_DATA_STROBE_OUT(dstb),
    .USER_IN_EN_OUT(in_en), .USER_OUT_EN_OUT(out_en), .OSC_RUN_OUT(osc),
    .BOOST_EN_OUT(boost));
  ppc_proc_model proc (.clk_in(clk), .busy_in(busy), .stat_in(sd), .oe_n_in(oe_n),
    .cs_out(cs), .wr_out(wr), .rd_out(rd), .sel_out(sel), .d_out(pd));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    chk("proc_wait", 8'h00, {7'h00, proc.hung});
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_stat(input logic [7:0] e);
    logic [7:0] s;
    logic o;
    proc.rd(s, o);
    chk("status", e, s);
    chk("oe_n", 8'h00, {7'h00, o});
  endtask
  // Counts cycles until busy drops; the count must land inside the window.
  task automatic wait_idle(input int lo, input int hi);
    int n;
    n = 0;
    while (busy !== 1'b0 && n <= hi)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy_len", 8'h01, 8'((n >= lo) && (n <= hi)));
    if (n > hi)
      give_verdict();
  endtask
  task automatic t_cmd();
    chk("rst", 8'hC0, {oe_n, osc, busy, in_en, out_en, boost, fstb, dstb});
    proc.wr(REG_SEL_CMD, 8'h31, 0);
    chk("cmd", 8'hE1, {fstb, in_en, busy, out_en, fc});
    chk_stat(8'h04);
    chk("out_en", 8'h01, {fstb, out_en});
    wait_idle(596, 642);
    chk_stat(8'h00);
  endtask
  task automatic t_rsvd();
    for (int c = 7; c < 16; c++)
    begin
      proc.wr(REG_SEL_CMD, 8'h20 | 8'(c), 1);
      chk("rsvd", 8'h41, {fstb, in_en, 2'b00, fc});
    end
  endtask
  task automatic t_row();
    row_end = 1'b1;
    proc.wr(REG_SEL_STATUS, 8'hA5, 0);
    row_end = 1'b0;
    chk("row", 8'h03, {dstb, busy});
    chk("cfg_data", 8'hA5, cd);
    proc.wr(REG_SEL_STATUS, 8'h5A, 1);
    chk("drop", 8'hA4, {cd[7:1], dstb});
    wait_idle(277, 322);
  endtask
  task automatic t_err();
    @(posedge clk);
    #1 row_err = 1'b1;
    @(posedge clk);
    #1 row_err = 1'b0;
    chk_stat(8'h02);
    id_err = 1'b1;
    @(posedge clk);
    #1 id_err = 1'b0;
    chk_stat(8'h03);
    proc.wr(REG_SEL_STATUS, 8'h11, 0);
    chk("err_drop", 8'h00, {7'h00, dstb});
    proc.wr(REG_SEL_CMD, 8'h20, 0);
    chk("in_refuse", 8'h00, {7'h00, in_en});
    proc.wr(REG_SEL_CMD, 8'h02, 0);
    chk_stat(8'h00);
    proc.wr(REG_SEL_STATUS, 8'h3C, 0);
    chk("load", 8'h3D, {cd[7:1], dstb});
    proc.wr(REG_SEL_CMD, 8'hB0, 0);
    @(posedge clk);
    #1;
    chk("boost", 8'h07, {boost, in_en, out_en});
  endtask
  task automatic t_osc();
    proc.wr(REG_SEL_CMD, 8'h40, 0);
    chk("osc_int", 8'h01, {7'h00, osc});
    ext_sel = 1'b1;
    proc.wr(REG_SEL_CMD, 8'h41, 0);
    chk("osc_ext", 8'h01, {osc, busy});
    repeat (16)
    begin
      chk("ext_busy", 8'h01, {7'h00, busy});
      @(posedge clk);
      #1 ext_clk = 1'b1;
      @(posedge clk);
      #1 ext_clk = 1'b0;
    end
    wait_idle(0, 10);
    proc.wr(REG_SEL_CMD, 8'h00, 0);
    chk("osc_on", 8'h01, {7'h00, osc});
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    t_cmd();
    t_rsvd();
    t_row();
    t_err();
    t_osc();
    give_verdict();
  end
endmodule
`default_nettype wire
